/* File: logic/ird_detector.v */
// crossing-filter flag comparators, power meter and register slave
//
// Strobed register access was decided locally.
`include "ird_consts.vh"
`default_nettype none
module ird_detector (
   input  wire        clk,
   input  wire        nrst,
   input  wire        sampleTick,
   input  wire [15:0] path0Value,
   input  wire [15:0] path1Value,
   input  wire [15:0] powerSample,
   input  wire [7:0]  regAddr,
   input  wire [7:0]  regWrData,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [7:0]  regRdData,
   output reg  [1:0]  path0Alarm,
   output reg  [1:0]  path1Alarm,
   output reg  [1:0]  powerAlarm,
   output reg  [15:0] powerAverage,
   output reg         irq
);
   reg [15:0] p0Upper_q, p0Lower_q, p1Upper_q, p1Lower_q;
   reg [15:0] dwell_q, pwrUpper_q, pwrLower_q;
   reg        p0Wide_q, p1Wide_q, pwrOn_q;
   reg [4:0]  winExp_q;
   reg [2:0]  irqStat_q, irqEn_q;
   reg        flag0_q, flag1_q, pwrFlag_q;
   reg [15:0] rel0_q, rel1_q;
   reg [16:0] winCnt_q;
   reg [32:0] acc_q;

   // signed 2.14 compare
   function above;
      input [15:0] a;
      input [15:0] b;
      begin
         above = $signed(a) > $signed(b);
      end
   endfunction

   // clamp out-of-range exponents so the window never exceeds 2^16
   wire [4:0]  expEff  = (winExp_q > `IRD_EXP_MAX) ? `IRD_EXP_MAX : winExp_q;
   wire [16:0] winLast = (17'h0_0001 << expEff) - 17'h0_0001;
   wire [32:0] accNext = acc_q + {17'h0_0000, powerSample};
   wire [32:0] avgFull = accNext >> expEff;
   wire [15:0] avgNew  = (|avgFull[32:16]) ? 16'hFFFF : avgFull[15:0];
   wire        winDone = pwrOn_q && sampleTick && (winCnt_q == winLast);

   wire p0Hi = above(path0Value, p0Upper_q);
   wire p0Lo = above(p0Lower_q, path0Value);
   wire p1Hi = above(path1Value, p1Upper_q);
   wire p1Lo = above(p1Lower_q, path1Value);

   // release fires when the below-lower run has lasted the dwell count
   wire rel0Done = sampleTick && p0Lo && (rel0_q >= dwell_q);
   wire rel1Done = sampleTick && p1Lo && (rel1_q >= dwell_q);
   wire set0 = sampleTick && p0Hi && !flag0_q;
   wire set1 = sampleTick && p1Hi && !flag1_q;
   wire pwrSet = winDone && (avgNew > pwrUpper_q);
   wire pwrClr = winDone && (avgNew < pwrLower_q);
   wire [2:0] evt = {pwrSet && !pwrFlag_q, set1, set0};

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         p0Upper_q  <= 16'h0000;
         p0Lower_q  <= 16'h0000;
         p1Upper_q  <= 16'h0000;
         p1Lower_q  <= 16'h0000;
         dwell_q    <= 16'h0000;
         pwrUpper_q <= 16'h0000;
         pwrLower_q <= 16'h0000;
         p0Wide_q   <= 1'b0;
         p1Wide_q   <= 1'b0;
         pwrOn_q    <= 1'b0;
         winExp_q   <= 5'h00;
         irqEn_q    <= 3'h0;
      end else if (regWr) begin
         case (regAddr)
            `IRD_P0_HI_LO:  p0Upper_q[7:0]   <= regWrData;
            `IRD_P0_HI_HI:  p0Upper_q[15:8]  <= regWrData;
            `IRD_P0_LO_LO:  p0Lower_q[7:0]   <= regWrData;
            `IRD_P0_LO_HI:  p0Lower_q[15:8]  <= regWrData;
            `IRD_P0_FMT:    p0Wide_q         <= regWrData[0];
            `IRD_P1_HI_LO:  p1Upper_q[7:0]   <= regWrData;
            `IRD_P1_HI_HI:  p1Upper_q[15:8]  <= regWrData;
            `IRD_P1_LO_LO:  p1Lower_q[7:0]   <= regWrData;
            `IRD_P1_LO_HI:  p1Lower_q[15:8]  <= regWrData;
            `IRD_P1_FMT:    p1Wide_q         <= regWrData[0];
            `IRD_DWELL_LO:  dwell_q[7:0]     <= regWrData;
            `IRD_DWELL_HI:  dwell_q[15:8]    <= regWrData;
            `IRD_PWR_ON:    pwrOn_q          <= regWrData[0];
            `IRD_PWR_EXP:   winExp_q         <= regWrData[4:0];
            `IRD_PWR_HI_LO: pwrUpper_q[7:0]  <= regWrData;
            `IRD_PWR_HI_HI: pwrUpper_q[15:8] <= regWrData;
            `IRD_PWR_LO_LO: pwrLower_q[7:0]  <= regWrData;
            `IRD_PWR_LO_HI: pwrLower_q[15:8] <= regWrData;
            `IRD_IRQ_EN:    irqEn_q          <= regWrData[2:0];
            default: ;
         endcase
      end
   end

   // path flags and release counters
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flag0_q <= 1'b0;
         flag1_q <= 1'b0;
         rel0_q  <= 16'h0000;
         rel1_q  <= 16'h0000;
      end else if (sampleTick) begin
         if (p0Hi)
            flag0_q <= 1'b1;
         else if (rel0Done)
            flag0_q <= 1'b0;
         if (p1Hi)
            flag1_q <= 1'b1;
         else if (rel1Done)
            flag1_q <= 1'b0;
         // any sample not below the lower limit restarts the run
         rel0_q <= (p0Lo && flag0_q && !rel0Done) ? rel0_q + 16'h0001 : 16'h0000;
         rel1_q <= (p1Lo && flag1_q && !rel1Done) ? rel1_q + 16'h0001 : 16'h0000;
      end
   end

   // power meter: window accumulate, average, hysteresis alarm
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         winCnt_q     <= 17'h0_0000;
         acc_q        <= 33'h0_0000_0000;
         pwrFlag_q    <= 1'b0;
         powerAverage <= 16'h0000;
      end else if (!pwrOn_q) begin
         winCnt_q <= 17'h0_0000;
         acc_q    <= 33'h0_0000_0000;
      end else if (sampleTick) begin
         if (winDone) begin
            winCnt_q     <= 17'h0_0000;
            acc_q        <= 33'h0_0000_0000;
            powerAverage <= avgNew;
            if (pwrSet)
               pwrFlag_q <= 1'b1;
            else if (pwrClr)
               pwrFlag_q <= 1'b0;
         end else begin
            winCnt_q <= winCnt_q + 17'h0_0001;
            acc_q    <= accNext;
         end
      end
   end

   // alarm outputs: wide format adds a second "below lower" bit
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         path0Alarm <= 2'b00;
         path1Alarm <= 2'b00;
         powerAlarm <= 2'b00;
      end else begin
         path0Alarm <= {p0Wide_q & p0Lo & ~flag0_q, flag0_q};
         path1Alarm <= {p1Wide_q & p1Lo & ~flag1_q, flag1_q};
         powerAlarm <= {1'b0, pwrFlag_q};
      end
   end

   // sticky events: a set in the clear cycle wins
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irqStat_q <= 3'h0;
         irq       <= 1'b0;
      end else begin
         irqStat_q <= (irqStat_q & ~((regWr && regAddr == `IRD_IRQ_CLR) ? regWrData[2:0] : 3'h0)) | evt;
         irq       <= |(irqStat_q & irqEn_q);
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         regRdData <= `IRD_RESET_VAL;
      else if (regRd) begin
         case (regAddr)
            `IRD_P0_HI_LO:    regRdData <= p0Upper_q[7:0];
            `IRD_P0_HI_HI:    regRdData <= p0Upper_q[15:8];
            `IRD_P0_LO_LO:    regRdData <= p0Lower_q[7:0];
            `IRD_P0_LO_HI:    regRdData <= p0Lower_q[15:8];
            `IRD_P0_FMT:      regRdData <= {7'h00, p0Wide_q};
            `IRD_P1_HI_LO:    regRdData <= p1Upper_q[7:0];
            `IRD_P1_HI_HI:    regRdData <= p1Upper_q[15:8];
            `IRD_P1_LO_LO:    regRdData <= p1Lower_q[7:0];
            `IRD_P1_LO_HI:    regRdData <= p1Lower_q[15:8];
            `IRD_P1_FMT:      regRdData <= {7'h00, p1Wide_q};
            `IRD_DWELL_LO:    regRdData <= dwell_q[7:0];
            `IRD_DWELL_HI:    regRdData <= dwell_q[15:8];
            `IRD_PWR_ON:      regRdData <= {7'h00, pwrOn_q};
            `IRD_PWR_EXP:     regRdData <= {3'h0, winExp_q};
            `IRD_PWR_HI_LO:   regRdData <= pwrUpper_q[7:0];
            `IRD_PWR_HI_HI:   regRdData <= pwrUpper_q[15:8];
            `IRD_PWR_LO_LO:   regRdData <= pwrLower_q[7:0];
            `IRD_PWR_LO_HI:   regRdData <= pwrLower_q[15:8];
            `IRD_IRQ_STAT:    regRdData <= {5'h00, irqStat_q};
            `IRD_IRQ_EN:      regRdData <= {5'h00, irqEn_q};
            `IRD_ALARM_STATE: regRdData <= {5'h00, pwrFlag_q, flag1_q, flag0_q};
            default:          regRdData <= 8'h00;
         endcase
      end else
         regRdData <= 8'h00;
   end
endmodule // ird_detector
`default_nettype wire

/* File: common/ird_consts.vh */
// constants for the crossing-filter flags and power meter block
// Overview of operation
// - two filter paths each compare their crossing result against an upper and a lower limit.
// - each limit is a 16-bit signed 2.14 value where 4000h means all crossings and 0800h one eighth.
// - a per-path bit picks a 1-bit (0) or 2-bit (1) comparator output.
// - a path flag sets when the path value rises above its upper limit.
// - a path flag clears only after the value stays below the lower limit unbroken for the release delay.
// - the release delay is a 16-bit count of clocks at one eighth of the sample rate.
// - the power meter runs only while its on bit is 1 and is idle while it is 0.
// - the averaging window is 2 to the power M clocks at one eighth sample rate, M from 0 to 16.
// - average power is compared with 16-bit upper and lower limits, one LSB being 2 to the minus 16.
`ifndef IRD_CONSTS_VH
`define IRD_CONSTS_VH
`define IRD_P0_HI_LO    8'h0F
`define IRD_P0_HI_HI    8'h10
`define IRD_P0_LO_LO    8'h11
`define IRD_P0_LO_HI    8'h12
`define IRD_P0_FMT      8'h13
`define IRD_P1_HI_LO    8'h16
`define IRD_P1_HI_HI    8'h17
`define IRD_P1_LO_LO    8'h18
`define IRD_P1_LO_HI    8'h19
`define IRD_P1_FMT      8'h1A
`define IRD_DWELL_LO    8'h1D
`define IRD_DWELL_HI    8'h1E
`define IRD_PWR_ON      8'h20
`define IRD_PWR_EXP     8'h21
`define IRD_PWR_HI_LO   8'h22
`define IRD_PWR_HI_HI   8'h23
`define IRD_PWR_LO_LO   8'h24
`define IRD_PWR_LO_HI   8'h25
`define IRD_IRQ_STAT    8'h28
`define IRD_IRQ_CLR     8'h29
`define IRD_IRQ_EN      8'h2A
`define IRD_ALARM_STATE 8'h2B
`define IRD_EXP_MAX     5'h10
`define IRD_RESET_VAL   8'h00
`endif

/* File: verif/ird_agc_model.sv */
// gain-control follower that reacts to the power alarm
`default_nettype none
module ird_agc_model (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [1:0] powerAlarm,
   output var  int         gainSteps
);
   timeunit 1ns;
   timeprecision 1ps;
   logic alarmSeen_q;
   // one step per new alarm; a held alarm must not pull the gain down again
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         alarmSeen_q <= 1'b0;
         gainSteps <= 0;
      end else begin
         alarmSeen_q <= powerAlarm[0];
         if (powerAlarm[0] && !alarmSeen_q) gainSteps <= gainSteps + 1;
      end
   end
endmodule // ird_agc_model
`default_nettype wire

/* File: verif/ird_detector_chk.sv */
// port-level checker for the detector block
`default_nettype none
module ird_detector_chk (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        sampleTick,
   input wire logic [7:0]  regAddr,
   input wire logic        regRd,
   input wire logic [7:0]  regRdData,
   input wire logic [1:0]  path0Alarm,
   input wire logic [1:0]  path1Alarm,
   input wire logic [1:0]  powerAlarm,
   input wire logic [15:0] powerAverage
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // flag register plus output register: three quiet cycles settle every tick-driven output
   sequence noTick;
      !sampleTick [*3];
   endsequence
   rd_idle_a: assert property (!regRd |=> regRdData == 8'h00)
      else $error("read data not idle");
   rd_unmapped_a: assert property (regRd && regAddr > 8'h2B |=> regRdData == 8'h00)
      else $error("unmapped read not zero");
   pwr_bit1_a: assert property (powerAlarm[1] == 1'b0)
      else $error("power alarm bit1 set");
   p0_tick_a: assert property ($changed(path0Alarm[0]) |-> $past(sampleTick, 2))
      else $error("path0 flag moved without tick");
   p1_tick_a: assert property ($changed(path1Alarm[0]) |-> $past(sampleTick, 2))
      else $error("path1 flag moved without tick");
   avg_tick_a: assert property ($changed(powerAverage) |-> $past(sampleTick))
      else $error("average moved without tick");
   pwr_tick_a: assert property ($changed(powerAlarm[0]) |-> $past(sampleTick) || $past(sampleTick, 2))
      else $error("power alarm moved without tick");
   quiet_hold_a: assert property (noTick |-> $stable(path0Alarm[0]) && $stable(powerAverage))
      else $error("outputs moved while idle");
endmodule // ird_detector_chk
bind ird_detector ird_detector_chk chk (.clk(clk), .nrst(nrst), .sampleTick(sampleTick), .regAddr(regAddr),
   .regRd(regRd), .regRdData(regRdData), .path0Alarm(path0Alarm), .path1Alarm(path1Alarm),
   .powerAlarm(powerAlarm), .powerAverage(powerAverage));
`default_nettype wire

/* File: verif/tb_iir_and_rms_power_detector.sv */
// self-checking bench for the detector block
`default_nettype none
`define CHK(s, e, a) begin tests_run++; if ((a) !== (e)) begin num_errors++; $display("CHECK FAILED %s exp %h got %h", s, e, a); end end
module tb_iir_and_rms_power_detector;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, nrst, sampleTick, regWr, regRd;
   logic [15:0] path0Value, path1Value, powerSample;
   logic [7:0]  regAddr, regWrData;
   wire  [7:0]  regRdData;
   wire  [1:0]  path0Alarm, path1Alarm, powerAlarm;
   wire  [15:0] powerAverage;
   wire         irq;
   int          num_errors = 0, tests_run = 0, gainSteps;
   ird_detector dut (.clk(clk), .nrst(nrst), .sampleTick(sampleTick), .path0Value(path0Value),
      .path1Value(path1Value), .powerSample(powerSample), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .path0Alarm(path0Alarm),
      .path1Alarm(path1Alarm), .powerAlarm(powerAlarm), .powerAverage(powerAverage), .irq(irq));
   ird_agc_model agc (.clk(clk), .nrst(nrst), .powerAlarm(powerAlarm), .gainSteps(gainSteps));
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      `CHK("read", e, regRdData)
   endtask
   // ticks are counted per high cycle, so a gap between calls adds none
   task tk(input int n);
      repeat (n) @(posedge clk) sampleTick <= 1'b1;
      @(posedge clk);
      sampleTick <= 1'b0;
   endtask
   task settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task t_regs;
      logic [7:0] ra [6] = '{8'h0F, 8'h13, 8'h1E, 8'h20, 8'h25, 8'h40};
      foreach (ra[i]) rd(ra[i], 8'h00);
      wr(8'h17, 8'hA5);
      rd(8'h17, 8'hA5);
      $display("registers done");
   endtask
   task t_path;
      wr(8'h10, 8'h08);
      wr(8'h12, 8'h04);
      wr(8'h1D, 8'h02);
      path0Value <= 16'hC000;
      tk(4);
      settle();
      `CHK("neg", 2'b00, path0Alarm)
      path0Value <= 16'h0801;
      tk(1);
      settle();
      `CHK("set", 2'b01, path0Alarm)
      `CHK("masked", 1'b0, irq)
      wr(8'h2A, 8'h01);
      settle();
      `CHK("irq", 1'b1, irq)
      rd(8'h28, 8'h01);
      wr(8'h29, 8'h01);
      settle();
      `CHK("cleared", 1'b0, irq)
      path0Value <= 16'h03FF;
      tk(2);
      path0Value <= 16'h0500;
      tk(1);
      path0Value <= 16'h03FF;
      tk(2);
      settle();
      `CHK("dwell", 2'b01, path0Alarm)
      tk(1);
      settle();
      `CHK("release", 2'b00, path0Alarm)
      wr(8'h13, 8'h01);
      tk(1);
      settle();
      `CHK("wide", 2'b10, path0Alarm)
      // path1 upper limit still holds A500h from the register test, so 0001h lies above it
      path1Value <= 16'h0001;
      tk(1);
      settle();
      `CHK("p1 set", 2'b01, path1Alarm)
      $display("path done");
   endtask
   task t_power;
      wr(8'h23, 8'h80);
      wr(8'h25, 8'h40);
      wr(8'h21, 8'h02);
      powerSample <= 16'h9000;
      tk(8);
      settle();
      `CHK("off", 16'h0000, powerAverage)
      wr(8'h20, 8'h01);
      tk(4);
      settle();
      `CHK("avg", 16'h9000, powerAverage)
      `CHK("high", 2'b01, powerAlarm)
      powerSample <= 16'h6000;
      tk(4);
      settle();
      `CHK("hold", 2'b01, powerAlarm)
      powerSample <= 16'h3FFF;
      tk(4);
      settle();
      `CHK("low", 2'b00, powerAlarm)
      `CHK("steps", 1, gainSteps)
      wr(8'h21, 8'h00);
      powerSample <= 16'h1234;
      tk(1);
      settle();
      `CHK("m0", 16'h1234, powerAverage)
      $display("power done");
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      print_verdict();
   end
   initial begin
      {nrst, sampleTick, regWr, regRd} = 4'h0;
      {regAddr, regWrData} = 16'h0000;
      {path0Value, powerSample} = 32'h0000_0000;
      // most negative value keeps path1 quiet until its own check
      path1Value = 16'h8000;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_regs();
      t_path();
      t_power();
      print_verdict();
   end
endmodule // tb_iir_and_rms_power_detector
`default_nettype wire
